/* bench/igb_board_model.sv */
// Board side of the input bank: pin levels, with empty positions left floating
`timescale 1ns/1ps
module igb_board_model (
	input wire logic clk_i,
	input wire logic [11:0] level_i,
	output logic [11:0] pin_o
);
	// Flips every cycle, so a floating position never holds a steady level
	logic scramble = 1'b0;
	always @(posedge clk_i) begin
		scramble <= ~scramble;
	end
	// Populated pins follow the board, absent ones float
	assign pin_o = (level_i & igb_pkg::IMPL_MASK) | ({12{scramble}} & ~igb_pkg::IMPL_MASK);
endmodule : igb_board_model

/* bench/testbench.sv */
// Self-checking bench: window moves, status, polarity, wells and pair steering
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [31:0] wdata_i = 32'h00000000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o;
	logic [11:0] pin_i;
	logic [11:0] level = 12'h000; // Board levels asked of the model
	logic core_on_i = 1'b1;
	logic resume_on_i = 1'b1;
	logic req_a_o;
	logic req_b_o;
	logic [1:0] pair_en_o;
	logic [15:0] window_base_o;
	logic [15:0] base = 16'h0000; // Where the bench expects the window
	int n_fail = 0;
	int check_count = 0;
	////////////////////////////////////////
	always #20 clk_i = ~clk_i;
	igb_board_model board (.clk_i(clk_i), .level_i(level), .pin_o(pin_i));
	igb_top dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .core_on_i(core_on_i), .resume_on_i(resume_on_i),
		.req_a_o(req_a_o), .req_b_o(req_b_o), .pair_en_o(pair_en_o), .window_base_o(window_base_o));
	////////////////////////////////////////
	// Address of a window offset at the current base
	function automatic logic [15:0] at(input logic [5:0] off);
		return base | {10'h000, off};
	endfunction : at
	// Edges, then a little settling time
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask : chk
	// One-cycle write strobe
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1;
		chk("rdata_o", exp, rdata_o);
	endtask : rd
	task automatic pins(input logic [11:0] v);
		@(posedge clk_i);
		level <= v;
		tick(2);
	endtask : pins
	task automatic wells(input logic c, input logic r);
		@(posedge clk_i);
		core_on_i <= c;
		resume_on_i <= r;
		tick(1);
	endtask : wells
	task automatic tally_and_finish();
		if (n_fail == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_i);
		chk("pair_en_o", 32'h0, 32'(pair_en_o));
		chk("req_a_o", 32'h1, 32'(req_a_o));
		chk("req_b_o", 32'h1, 32'(req_b_o));
		reset_n_i <= 1'b1;
		rd(igb_pkg::BASE_REG_ADDR, 32'h0);
		rd(at(igb_pkg::OFF_USE_SEL), 32'h3);
		rd(at(igb_pkg::OFF_EVT_STS), 32'h0);
		// All pins high: only populated positions report
		pins(12'hfff);
		rd(at(igb_pkg::OFF_EVT_STS), 32'hbe3);
		rd(at(igb_pkg::OFF_RAW), 32'hbe3);
		// Status is read only: a write there changes nothing
		wr(at(igb_pkg::OFF_EVT_STS), 32'h0);
		rd(at(igb_pkg::OFF_EVT_STS), 32'hbe3);
		wr(at(igb_pkg::OFF_INV), 32'hfff);
		rd(at(igb_pkg::OFF_INV), 32'hbe3);
		rd(at(igb_pkg::OFF_EVT_STS), 32'h0);
		pins(12'h000);
		rd(at(igb_pkg::OFF_EVT_STS), 32'hbe3);
		// Each well gates only its own pins
		wells(1'b0, 1'b1);
		rd(at(igb_pkg::OFF_EVT_STS), 32'hb00);
		wells(1'b1, 1'b0);
		rd(at(igb_pkg::OFF_EVT_STS), 32'h0e3);
		wells(1'b1, 1'b1);
		// Move the window; low bits of the base are dropped
		wr(at(igb_pkg::OFF_INV), 32'h0);
		pins(12'h020);
		wr(igb_pkg::BASE_REG_ADDR, 32'h127f);
		base = 16'h1240;
		tick(2);
		chk("window_base_o", 32'h1240, 32'(window_base_o));
		rd(igb_pkg::BASE_REG_ADDR, 32'h1240);
		// Read data stand for one cycle only
		tick(1);
		chk("rdata_o", 32'h0, rdata_o);
		rd(at(igb_pkg::OFF_EVT_STS), 32'h020);
		// A write to the old window place is ignored
		wr(16'h002c, 32'hfff);
		rd(at(igb_pkg::OFF_INV), 32'h0);
		rd(16'h000c, 32'h0);
		rd(base + 16'h004c, 32'h0);
		rd(base - 16'h0034, 32'h0);
		// Hand both pins to the request pairs
		wr(at(igb_pkg::OFF_USE_SEL), 32'h0);
		pins(12'h002);
		chk("pair_en_o", 32'h3, 32'(pair_en_o));
		chk("req_a_o", 32'h0, 32'(req_a_o));
		chk("req_b_o", 32'h1, 32'(req_b_o));
		pins(12'h001);
		chk("req_a_o", 32'h1, 32'(req_a_o));
		chk("req_b_o", 32'h0, 32'(req_b_o));
		// Pin 0 back to general use: pair A idles high
		wr(at(igb_pkg::OFF_USE_SEL), 32'h1);
		pins(12'h000);
		chk("pair_en_o", 32'h2, 32'(pair_en_o));
		chk("req_a_o", 32'h1, 32'(req_a_o));
		chk("req_b_o", 32'h0, 32'(req_b_o));
		rd(at(igb_pkg::OFF_USE_SEL), 32'h1);
		// Only pin 0 handed over: pair B idles high
		wr(at(igb_pkg::OFF_USE_SEL), 32'h2);
		pins(12'h002);
		chk("pair_en_o", 32'h1, 32'(pair_en_o));
		chk("req_a_o", 32'h0, 32'(req_a_o));
		chk("req_b_o", 32'h1, 32'(req_b_o));
		// Reset again in mid-run: every register returns to its reset value
		@(posedge clk_i);
		reset_n_i <= 1'b0;
		tick(2);
		chk("pair_en_o", 32'h0, 32'(pair_en_o));
		chk("req_a_o", 32'h1, 32'(req_a_o));
		chk("window_base_o", 32'h0, 32'(window_base_o));
		@(posedge clk_i);
		reset_n_i <= 1'b1;
		base = 16'h0000;
		rd(at(igb_pkg::OFF_USE_SEL), 32'h3);
		rd(at(igb_pkg::OFF_INV), 32'h0);
		rd(at(igb_pkg::OFF_EVT_STS), 32'h002);
		tally_and_finish();
	end
endmodule : testbench

/* hdl/igb_status_bit.sv */
// One status cell: polarity, well gating and implemented-pin gating
`timescale 1ns/1ps
module igb_status_bit #(
	parameter bit IMPL = 1'b1
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic pin_i,
	input wire logic invert_i,
	input wire logic well_on_i,
	output logic active_o
);

	// Active level: high pin unless inverted; absent pins stay zero
	wire active_now = IMPL & well_on_i & (pin_i ^ invert_i);

	// Registered so the status reads as a clean level
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			active_o <= 1'b0;
		end else begin
			active_o <= active_now;
		end
	end

endmodule : igb_status_bit

/* hdl/igb_top.sv */
// Input general-purpose bank: relocatable window, status, polarity and pair steering
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module igb_top (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic [11:0] pin_i,
	input wire logic core_on_i,
	input wire logic resume_on_i,
	output logic req_a_o,
	output logic req_b_o,
	output logic [1:0] pair_en_o,
	output logic [15:0] window_base_o
);

	////////////////////////////////////////////////////////////////////////
	// Bus request bundle
	igb_pkg::igb_req_s req;
	assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

	////////////////////////////////////////////////////////////////////////
	// Control state
	logic [15:0] base; // Window base, aligned
	logic [1:0] use_sel; // 1 = pin is general purpose, 0 = pair
	logic [11:0] inv; // Polarity invert per pin
	logic [11:0] status; // Registered active state
	logic [11:0] raw; // Registered raw pin levels

	////////////////////////////////////////////////////////////////////////
	// Address decode
	// Window hit compares only upper bits, so the window is 64 bytes wide
	wire in_win = ((req.addr & igb_pkg::WIN_MASK) == base);
	wire [5:0] off = req.addr[5:0];
	wire hit_base = (req.addr == igb_pkg::BASE_REG_ADDR);
	wire hit_sel = in_win && (off == igb_pkg::OFF_USE_SEL);
	wire hit_sts = in_win && (off == igb_pkg::OFF_EVT_STS);
	wire hit_inv = in_win && (off == igb_pkg::OFF_INV);
	wire hit_raw = in_win && (off == igb_pkg::OFF_RAW);

	// Status and raw levels are read only; writes there fall through
	// Next values for writes
	wire [15:0] next_base = req.wdata[15:0] & igb_pkg::WIN_MASK;
	wire [11:0] next_inv = req.wdata[11:0] & igb_pkg::IMPL_MASK;

	////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			base <= igb_pkg::BASE_RESET;
			use_sel <= igb_pkg::USE_SEL_RESET;
			inv <= igb_pkg::INV_RESET;
		end else if (req.wr) begin
			// Base lives outside the window so it can never be lost
			if (hit_base) begin
				base <= next_base;
			end
			// Use-select: 1 keeps the pin general purpose
			if (hit_sel) begin
				use_sel <= req.wdata[1:0];
			end
			// Invert bits of absent positions never stick
			if (hit_inv) begin
				inv <= next_inv;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-pin status cells, gated by well power
	// A powered-down well forces its pins inactive, whatever the level
	wire [11:0] well_on = ({12{core_on_i}} & igb_pkg::CORE_MASK) | ({12{resume_on_i}} & igb_pkg::RESUME_MASK);
	// One cell per position; absent positions are built but tied off
	genvar g;
	generate
		for (g = 0; g < igb_pkg::NPIN; g++) begin : g_bit
			igb_status_bit #(
				.IMPL(igb_pkg::IMPL_MASK[g])
			) u_bit (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.pin_i(pin_i[g]),
				.invert_i(inv[g]),
				.well_on_i(well_on[g]),
				.active_o(status[g])
			);
		end
	endgenerate

	// Raw levels for the raw-level read; the pair paths take pin_i directly
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			raw <= 12'h000;
		end else begin
			raw <= pin_i & igb_pkg::IMPL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pair steering: pin reaches the arbiter only when handed over
	// Request pins are active low, so an idle pair sees high
	// Registered so the arbiter never sees a glitch from the decode
	wire next_req_a = use_sel[igb_pkg::SEL_PAIR_A] ? 1'b1 : pin_i[0];
	wire next_req_b = use_sel[igb_pkg::SEL_PAIR_B] ? 1'b1 : pin_i[1];

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			req_a_o <= 1'b1;
			req_b_o <= 1'b1;
			pair_en_o <= ~igb_pkg::USE_SEL_RESET; // Pairs released at reset
			window_base_o <= igb_pkg::BASE_RESET;
		end else begin
			req_a_o <= next_req_a;
			req_b_o <= next_req_b;
			pair_en_o <= ~use_sel;
			window_base_o <= base;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux; unmapped addresses return zero
	wire [31:0] rd_mux =
		hit_base ? {16'h0000, base} :
		hit_sel ? {30'h0, use_sel} :
		hit_sts ? {20'h0, status} :
		hit_inv ? {20'h0, inv} :
		hit_raw ? {20'h0, raw} :
		32'h0000_0000;

	// Read data stand for one cycle only, then fall back to zero
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 32'h0000_0000;
		end else if (req.rd) begin
			rdata_o <= rd_mux;
		end else begin
			rdata_o <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_absent_zero;
		@(posedge clk_i) disable iff (!reset_n_i)
		(status & ~igb_pkg::IMPL_MASK) == 12'h000;
	endproperty
	a_absent_zero: assert property (p_absent_zero) else $error("absent status bit set");

	property p_inv_absent;
		@(posedge clk_i) disable iff (!reset_n_i)
		(inv & ~igb_pkg::IMPL_MASK) == 12'h000;
	endproperty
	a_inv_absent: assert property (p_inv_absent) else $error("absent invert bit set");

	property p_status_follow;
		@(posedge clk_i) disable iff (!reset_n_i)
		(core_on_i && !(req.wr && hit_inv)) |=> status[0] == ($past(pin_i[0]) ^ inv[0]);
	endproperty
	a_status_follow: assert property (p_status_follow) else $error("status 0 wrong");

	property p_status_res;
		@(posedge clk_i) disable iff (!reset_n_i)
		(resume_on_i && !(req.wr && hit_inv)) |=> status[11] == ($past(pin_i[11]) ^ inv[11]);
	endproperty
	a_status_res: assert property (p_status_res) else $error("status 11 wrong");

	property p_base_move;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req.wr && hit_base) |=> ##1 window_base_o == ($past(req.wdata[15:0], 2) & igb_pkg::WIN_MASK);
	endproperty
	a_base_move: assert property (p_base_move) else $error("base not moved");

	property p_window_size;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req.rd && ((req.addr & igb_pkg::WIN_MASK) != base) && !hit_base) |=> rdata_o == 32'h0000_0000;
	endproperty
	a_window_size: assert property (p_window_size) else $error("read outside window");

	property p_pair_a;
		@(posedge clk_i) disable iff (!reset_n_i)
		!use_sel[igb_pkg::SEL_PAIR_A] |=> req_a_o == $past(pin_i[0]);
	endproperty
	a_pair_a: assert property (p_pair_a) else $error("pair A not steered");

	property p_pair_b;
		@(posedge clk_i) disable iff (!reset_n_i)
		use_sel[igb_pkg::SEL_PAIR_B] |=> req_b_o && !pair_en_o[1];
	endproperty
	a_pair_b: assert property (p_pair_b) else $error("pair B leaked");

	// While handed over, pin 1 reaches pair B one cycle late
	property p_pair_b_follow;
		@(posedge clk_i) disable iff (!reset_n_i)
		!use_sel[igb_pkg::SEL_PAIR_B] |=> req_b_o == $past(pin_i[1]);
	endproperty
	a_pair_b_follow: assert property (p_pair_b_follow) else $error("pair B not steered");

	// A general-purpose pin 0 leaves pair A idle and released
	property p_pair_a_idle;
		@(posedge clk_i) disable iff (!reset_n_i)
		use_sel[igb_pkg::SEL_PAIR_A] |=> req_a_o && !pair_en_o[0];
	endproperty
	a_pair_a_idle: assert property (p_pair_a_idle) else $error("pair A leaked");

	// Pair enables track the select bits with one cycle of lag
	property p_pair_en;
		@(posedge clk_i) disable iff (!reset_n_i)
		1'b1 |=> pair_en_o == ~$past(use_sel);
	endproperty
	a_pair_en: assert property (p_pair_en) else $error("pair enable wrong");

	// A select write lands in the next cycle
	property p_sel_write;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req.wr && hit_sel) |=> use_sel == $past(req.wdata[1:0]);
	endproperty
	a_sel_write: assert property (p_sel_write) else $error("select not written");

	////////////////////////////////////////////////////////////////////////
	// Window checks

	// The window base stays aligned on the window size
	property p_base_aligned;
		@(posedge clk_i) disable iff (!reset_n_i)
		(window_base_o & (igb_pkg::WIN_SIZE - 16'h0001)) == 16'h0000;
	endproperty
	a_base_aligned: assert property (p_base_aligned) else $error("window base unaligned");

	// The base register reads back through its own address
	property p_base_read;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req.rd && hit_base) |=> rdata_o == {16'h0000, $past(base)};
	endproperty
	a_base_read: assert property (p_base_read) else $error("base read wrong");

	// The select register reads back inside the window
	property p_sel_read;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req.rd && hit_sel) |=> rdata_o == {30'h0, $past(use_sel)};
	endproperty
	a_sel_read: assert property (p_sel_read) else $error("select read wrong");

	// Read data fall to zero when no read was taken
	property p_rd_idle;
		@(posedge clk_i) disable iff (!reset_n_i)
		!req.rd |=> rdata_o == 32'h0000_0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");

	////////////////////////////////////////////////////////////////////////
	// Status and polarity checks

	// The status register reads the registered active levels
	property p_sts_read;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req.rd && hit_sts) |=> rdata_o == {20'h0, $past(status)};
	endproperty
	a_sts_read: assert property (p_sts_read) else $error("status read wrong");

	// The invert register reads back
	property p_inv_read;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req.rd && hit_inv) |=> rdata_o == {20'h0, $past(inv)};
	endproperty
	a_inv_read: assert property (p_inv_read) else $error("invert read wrong");

	// An invert write keeps only populated positions
	property p_inv_write;
		@(posedge clk_i) disable iff (!reset_n_i)
		(req.wr && hit_inv) |=> inv == ($past(req.wdata[11:0]) & igb_pkg::IMPL_MASK);
	endproperty
	a_inv_write: assert property (p_inv_write) else $error("invert not written");

	// Core well off clears its own status bits
	property p_core_off;
		@(posedge clk_i) disable iff (!reset_n_i)
		!core_on_i |=> (status & igb_pkg::CORE_MASK) == 12'h000;
	endproperty
	a_core_off: assert property (p_core_off) else $error("core status while off");

	// Resume well off clears its own status bits
	property p_resume_off;
		@(posedge clk_i) disable iff (!reset_n_i)
		!resume_on_i |=> (status & igb_pkg::RESUME_MASK) == 12'h000;
	endproperty
	a_resume_off: assert property (p_resume_off) else $error("resume status while off");

	// Raw levels never show absent positions, even when they float
	property p_raw_absent;
		@(posedge clk_i) disable iff (!reset_n_i)
		(raw & ~igb_pkg::IMPL_MASK) == 12'h000;
	endproperty
	a_raw_absent: assert property (p_raw_absent) else $error("absent raw bit set");

endmodule : igb_top

/* inc/igb_pkg.sv */
// Package for the input general-purpose bank: window map, field layouts and reset values
package igb_pkg;

	// Register port widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// Window geometry: 64 bytes, aligned on 64
	localparam logic [15:0] WIN_SIZE = 16'h0040;
	localparam logic [15:0] WIN_MASK = 16'hffc0;
	localparam logic [15:0] BASE_RESET = 16'h0000;

	// Register that holds the window base, outside the window
	localparam logic [15:0] BASE_REG_ADDR = 16'hfff0;

	// Offsets inside the window
	localparam logic [5:0] OFF_USE_SEL = 6'h00;
	localparam logic [5:0] OFF_EVT_STS = 6'h0c;
	localparam logic [5:0] OFF_INV = 6'h2c;
	localparam logic [5:0] OFF_RAW = 6'h10;

	// Pin population
	localparam int NPIN = 12;
	localparam logic [11:0] CORE_MASK = 12'h0e3;
	localparam logic [11:0] RESUME_MASK = 12'hb00;
	localparam logic [11:0] IMPL_MASK = 12'hbe3;

	// Function-select bits
	localparam int SEL_PAIR_A = 0;
	localparam int SEL_PAIR_B = 1;
	localparam logic [1:0] USE_SEL_RESET = 2'h3;
	localparam logic [11:0] INV_RESET = 12'h000;

	// Bus request carried as one struct
	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} igb_req_s;

endpackage : igb_pkg
